// [pkg/sli_pkg.sv]
// Purpose: Constants for the front-panel status indicator controller.
// Assumes: 200 MHz aclk, AXI4-Lite register access, 32-bit data.
// Notes:   Offsets are byte addresses; each register is one aligned word.
package sli_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned GAP_MS        = 1000;   // Dark gap after a run
  localparam int unsigned LONG_MS       = 600;
  localparam int unsigned SHORT_MS      = 150;
  localparam int unsigned SPACE_MS      = 300;    // Dark between bits
  localparam int unsigned BLIP_MS       = 50;     // Reduced-power blink
  localparam int unsigned GAP_CYC       = GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned LONG_CYC      = LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned SHORT_CYC     = SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned SPACE_CYC     = SPACE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLIP_CYC      = BLIP_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] OFS_CODE   = 8'h00; // Status code
  localparam logic [7:0] OFS_CTRL   = 8'h04; // Control flags
  localparam logic [7:0] OFS_STATE  = 8'h08; // Run/force/mode state
  localparam logic [7:0] OFS_DOUT   = 8'h0c; // Digital output points
  localparam logic [7:0] OFS_AICFG  = 8'h10; // Analog current select
  localparam logic [7:0] OFS_LEDS   = 8'h14; // Read-back of counter and point LED image, with sequencer state

  // Control bits
  localparam int unsigned CTL_LED_EN  = 0;
  localparam int unsigned CTL_IOMASK  = 1;
  localparam int unsigned CTL_EXTAMP1 = 2;
  localparam int unsigned CTL_EXTAMP2 = 3;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;

  // State bits
  localparam int unsigned ST_RUN   = 0;
  localparam int unsigned ST_FORCE = 1;
  localparam int unsigned ST_MODE  = 2; // Two bits: power mode

  // Power modes
  typedef enum logic [1:0] {
    SLI_PM_NORMAL  = 2'h0,
    SLI_PM_REDUCED = 2'h1,
    SLI_PM_SLEEP   = 2'h2
  } sli_pm_t;

  // Status sequencer states, Gray along the path except the FLASH to GAP step
  typedef enum logic [1:0] {
    SLI_IDLE  = 2'b00,
    SLI_FLASH = 2'b01,
    SLI_SPACE = 2'b11,
    SLI_GAP   = 2'b10
  } sli_st_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sli_pkg

// [src/sli_top.sv]
// Purpose: Drives front-panel diagnostic LEDs from software and live state.
// Assumes: Inputs synchronous to aclk; LED outputs are active high.
// Notes:   Status code flashes LSB first; long flash is a one bit.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
module sli_top #(
  parameter int unsigned NPORT     = 3,
  parameter int unsigned NDI       = 8,
  parameter int unsigned NDO       = 8,
  parameter int unsigned NAI       = 8,
  parameter int unsigned CODE_W    = 8,
  parameter int unsigned GAP_CYC   = sli_pkg::GAP_CYC,
  parameter int unsigned LONG_CYC  = sli_pkg::LONG_CYC,
  parameter int unsigned SHORT_CYC = sli_pkg::SHORT_CYC,
  parameter int unsigned SPACE_CYC = sli_pkg::SPACE_CYC,
  parameter int unsigned BLIP_CYC  = sli_pkg::BLIP_CYC
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  input  wire logic             io_module_fault,
  input  wire logic [NPORT-1:0] port_rx_active,
  input  wire logic [NPORT-1:0] port_tx_active,
  input  wire logic [NPORT-1:0] port_cts,
  input  wire logic [NPORT-1:0] port_dcd,
  input  wire logic [2:0]       cnt_present,
  input  wire logic [2:0]       cnt_level,
  input  wire logic [2:0]       cnt_pulse,
  input  wire logic [NDI-1:0]   din_point,
  input  wire logic [NAI-1:0]   ai_range_err,
  output logic                  led_status,
  output logic                  led_power,
  output logic                  led_run,
  output logic                  led_force,
  output logic [NPORT-1:0]      led_rx,
  output logic [NPORT-1:0]      led_tx,
  output logic [NPORT-1:0]      led_cts,
  output logic [NPORT-1:0]      led_dcd,
  output logic [2:0]            led_cnt,
  output logic [NDI-1:0]        led_din,
  output logic [NDO-1:0]        led_dout,
  output logic [NAI-1:0]        led_ai
);

  // ==========================================================
  // State record
  // ==========================================================
  typedef struct packed {
    logic              aw_hold;
    logic [7:0]        aw_addr;
    logic              w_hold;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [CODE_W-1:0] code;
    logic [31:0]       ctrl;
    logic [3:0]        state;
    logic [NDO-1:0]    dout;
    logic [NAI-1:0]    ai_cur;
    sli_pkg::sli_st_t  seq;
    logic [CODE_W-1:0] shift;
    logic [31:0]       tmr;
    logic              stat_on;
    logic [31:0]       sec_cnt;
    logic [31:0]       slow_cnt;
    logic              slow_ph;
    logic [31:0]       fast_cnt;
    logic              fast_ph;
    logic [38:0]       leds;
  } sli_state_t;

  sli_state_t st_r;
  sli_state_t st_nxt;

  // Effective code after the module-fault mask; bit 0 is that indication
  logic [CODE_W-1:0] eff_code;

  // Place a written word into a stored value under byte strobes
  function automatic logic [31:0] sli_merge(input logic [31:0] old,
                                            input logic [31:0] val,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction : sli_merge

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rv;
    logic        hit;
    logic        en;
    logic [1:0]  mode;
    logic        pwr;
    logic [2:0]  cnt;
    logic [NAI-1:0] ai;
    wr_go  = 1'b0;
    rd_go  = 1'b0;
    rv     = 32'h0000_0000;
    hit    = 1'b1;
    en     = 1'b0;
    mode   = 2'h0;
    pwr    = 1'b0;
    cnt    = 3'h0;
    ai     = '0;
    st_nxt = st_r;

    // Status code masked: a set mask blocks the module fault input and clears a code of exactly one
    eff_code = st_r.code;
    if (st_r.ctrl[sli_pkg::CTL_IOMASK] && eff_code == CODE_W'(1)) begin
      eff_code = '0;
    end
    if (io_module_fault && !st_r.ctrl[sli_pkg::CTL_IOMASK]) begin
      eff_code[0] = 1'b1;
    end

    // Write address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_hold) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_hold) begin
      st_nxt.w_hold = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    wr_go = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
    if (wr_go) begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = sli_pkg::RESP_OKAY;
      case ({st_r.aw_addr[7:2], 2'b00})
        sli_pkg::OFS_CODE: begin
          st_nxt.code = CODE_W'(sli_merge(32'(st_r.code), st_r.w_data,
                                          st_r.w_strb));
        end
        sli_pkg::OFS_CTRL: begin
          st_nxt.ctrl = sli_merge(st_r.ctrl, st_r.w_data, st_r.w_strb);
        end
        sli_pkg::OFS_STATE: begin
          st_nxt.state = 4'(sli_merge(32'(st_r.state), st_r.w_data,
                                      st_r.w_strb));
        end
        sli_pkg::OFS_DOUT: begin
          st_nxt.dout = NDO'(sli_merge(32'(st_r.dout), st_r.w_data,
                                       st_r.w_strb));
        end
        sli_pkg::OFS_AICFG: begin
          st_nxt.ai_cur = NAI'(sli_merge(32'(st_r.ai_cur), st_r.w_data,
                                         st_r.w_strb));
        end
        sli_pkg::OFS_LEDS: begin
          st_nxt.bresp = sli_pkg::RESP_OKAY; // Read-only, write ignored
        end
        default: begin
          st_nxt.bresp = sli_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read channel: one cycle from address to data
    rd_go = s_axi_arvalid && !st_r.rvalid;
    if (rd_go) begin
      case ({s_axi_araddr[7:2], 2'b00})
        sli_pkg::OFS_CODE:  rv = 32'(st_r.code);
        sli_pkg::OFS_CTRL:  rv = st_r.ctrl;
        sli_pkg::OFS_STATE: rv = 32'(st_r.state);
        sli_pkg::OFS_DOUT:  rv = 32'(st_r.dout);
        sli_pkg::OFS_AICFG: rv = 32'(st_r.ai_cur);
        sli_pkg::OFS_LEDS:  rv = {st_r.seq, 2'b00, st_r.leds[27:0]};
        default: begin
          hit = 1'b0;
        end
      endcase
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rv;
      st_nxt.rresp  = hit ? sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Status code sequencer
    if (st_r.tmr != 32'h0000_0000) begin
      st_nxt.tmr = st_r.tmr - 32'h0000_0001;
    end
    case (st_r.seq)
      sli_pkg::SLI_IDLE: begin
        st_nxt.stat_on = 1'b0;
        if (eff_code != '0) begin
          // Latch code so a change to another nonzero code only lands on the next repetition
          st_nxt.seq     = sli_pkg::SLI_FLASH;
          st_nxt.shift   = eff_code;
          st_nxt.stat_on = 1'b1;
          st_nxt.tmr     = eff_code[0] ? LONG_CYC - 1 : SHORT_CYC - 1;
        end
      end
      sli_pkg::SLI_FLASH: begin
        if (st_r.tmr == 32'h0000_0000) begin
          st_nxt.stat_on = 1'b0;
          st_nxt.shift   = st_r.shift >> 1;
          if ((st_r.shift >> 1) == '0) begin
            st_nxt.seq = sli_pkg::SLI_GAP;
            st_nxt.tmr = GAP_CYC - 1;
          end else begin
            st_nxt.seq = sli_pkg::SLI_SPACE;
            st_nxt.tmr = SPACE_CYC - 1;
          end
        end
      end
      sli_pkg::SLI_SPACE: begin
        if (st_r.tmr == 32'h0000_0000) begin
          st_nxt.seq     = sli_pkg::SLI_FLASH;
          st_nxt.stat_on = 1'b1;
          st_nxt.tmr     = st_r.shift[0] ? LONG_CYC - 1 : SHORT_CYC - 1;
        end
      end
      sli_pkg::SLI_GAP: begin
        if (st_r.tmr == 32'h0000_0000) begin
          st_nxt.seq = sli_pkg::SLI_IDLE;
        end
      end
      default: begin
        st_nxt.seq = sli_pkg::SLI_IDLE;
      end
    endcase
    if (eff_code == '0) begin
      st_nxt.seq     = sli_pkg::SLI_IDLE;
      st_nxt.stat_on = 1'b0;
    end

    // One-second beat for the reduced-power blink
    if (st_r.sec_cnt >= GAP_CYC - 1) begin
      st_nxt.sec_cnt = 32'h0000_0000;
    end else begin
      st_nxt.sec_cnt = st_r.sec_cnt + 32'h0000_0001;
    end

    // Analog error flash phases: slow for long, fast for short
    if (st_r.slow_cnt >= LONG_CYC - 1) begin
      st_nxt.slow_cnt = 32'h0000_0000;
      st_nxt.slow_ph  = !st_r.slow_ph;
    end else begin
      st_nxt.slow_cnt = st_r.slow_cnt + 32'h0000_0001;
    end
    if (st_r.fast_cnt >= SHORT_CYC - 1) begin
      st_nxt.fast_cnt = 32'h0000_0000;
      st_nxt.fast_ph  = !st_r.fast_ph;
    end else begin
      st_nxt.fast_cnt = st_r.fast_cnt + 32'h0000_0001;
    end

    // LED image
    en   = st_r.ctrl[sli_pkg::CTL_LED_EN];
    mode = st_r.state[sli_pkg::ST_MODE +: 2];
    case (mode)
      sli_pkg::SLI_PM_NORMAL:  pwr = 1'b1;
      sli_pkg::SLI_PM_REDUCED: pwr = st_r.sec_cnt < BLIP_CYC;
      default:                 pwr = 1'b0;
    endcase
    pwr = pwr && en;
    cnt[0] = cnt_present[0] && !cnt_level[0];
    cnt[1] = st_r.ctrl[sli_pkg::CTL_EXTAMP1] ?
             (cnt_present[1] && !cnt_level[1]) : cnt_pulse[1];
    cnt[2] = st_r.ctrl[sli_pkg::CTL_EXTAMP2] ?
             (cnt_present[2] && !cnt_level[2]) : cnt_pulse[2];
    for (int i = 0; i < NAI; i++) begin
      if (ai_range_err[i]) begin
        ai[i] = st_r.ai_cur[i] ? st_r.slow_ph : st_r.fast_ph;
      end else begin
        ai[i] = st_r.ai_cur[i];
      end
    end
    st_nxt.leds = {st_r.stat_on, pwr, st_r.state[sli_pkg::ST_RUN],
                   st_r.state[sli_pkg::ST_FORCE], 35'(cnt)};
    st_nxt.leds[3 +: 8] = en ? 8'(st_r.dout) : 8'h00;
    st_nxt.leds[11 +: 8] = en ? 8'(din_point) : 8'h00;
    st_nxt.leds[19 +: 8] = en ? 8'(ai) : 8'h00;
    st_nxt.leds[27]      = 1'b0;
    st_nxt.leds[28 +: 4] = 4'h0;
    st_nxt.leds[32 +: 3] = 3'h0;
    if (!en) begin
      st_nxt.leds[38:35] = {1'b0, pwr, 2'b00};
      st_nxt.leds[2:0]   = 3'h0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.ctrl <= sli_pkg::CTRL_RST;
      st_r.seq  <= sli_pkg::SLI_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Port-activity LEDs registered beside the record; global disable darkens
  logic [NPORT-1:0] rx_r;
  logic [NPORT-1:0] tx_r;
  logic [NPORT-1:0] cts_r;
  logic [NPORT-1:0] dcd_r;
  logic [NDI-1:0]   din_r;
  logic [NDO-1:0]   dout_r;
  logic [NAI-1:0]   ai_r;

  // Wide point LEDs kept full width here so parameters above 8 still work
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_r   <= '0;
      tx_r   <= '0;
      cts_r  <= '0;
      dcd_r  <= '0;
      din_r  <= '0;
      dout_r <= '0;
      ai_r   <= '0;
    end else begin
      rx_r   <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? port_rx_active : '0;
      tx_r   <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? port_tx_active : '0;
      cts_r  <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? port_cts : '0;
      dcd_r  <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? port_dcd : '0;
      din_r  <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? din_point : '0;
      dout_r <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? st_r.dout : '0;
      ai_r   <= st_r.ctrl[sli_pkg::CTL_LED_EN] ? st_nxt_ai() : '0;
    end
  end

  // Analog image recomputed at full width
  function automatic logic [NAI-1:0] st_nxt_ai();
    logic [NAI-1:0] a;
    a = st_r.ai_cur;
    for (int i = 0; i < NAI; i++) begin
      if (ai_range_err[i]) begin
        a[i] = st_r.ai_cur[i] ? st_r.slow_ph : st_r.fast_ph;
      end
    end
    return a;
  endfunction : st_nxt_ai

  // ==========================================================
  // Outputs
  // ==========================================================
  assign s_axi_awready = !st_r.aw_hold;
  assign s_axi_wready  = !st_r.w_hold;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign led_status    = st_r.leds[38] && st_r.ctrl[sli_pkg::CTL_LED_EN];
  assign led_power     = st_r.leds[37];
  assign led_run       = st_r.leds[36] && st_r.ctrl[sli_pkg::CTL_LED_EN];
  assign led_force     = st_r.leds[35] && st_r.ctrl[sli_pkg::CTL_LED_EN];
  assign led_cnt       = st_r.leds[2:0];
  assign led_rx        = rx_r;
  assign led_tx        = tx_r;
  assign led_cts       = cts_r;
  assign led_dcd       = dcd_r;
  assign led_din       = din_r;
  assign led_dout      = dout_r;
  assign led_ai        = ai_r;

endmodule : sli_top

// [verif/sli_panel.sv]
// Purpose: Front-panel model that times the status indicator.
// Assumes: The indicator is lit while its drive is high.
// Notes:   Each lit or dark stretch is reported when it ends.
module sli_panel (
  input  wire logic aclk,
  input  wire logic led_status,
  output logic      seg_done,
  output logic      seg_lit,
  output int        seg_len
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_r = 1'h0;
  int   cnt_r = 0;

  // ======
  // Stretch timer: one pulse per change of the indicator
  initial seg_done = 1'h0;
  always @(posedge aclk) begin
    seg_done <= (led_status !== prev_r);
    seg_lit  <= prev_r;
    seg_len  <= cnt_r;
    cnt_r    <= (led_status !== prev_r) ? 1 : cnt_r + 1;
    prev_r   <= led_status;
  end
endmodule : sli_panel

// [verif/sli_top_sva.sv]
// Purpose: Port-level assertions for the indicator controller.
// Assumes: Bound to every sli_top instance; one clock domain.
// Notes:   Flash length is judged only on flashes no write disturbed.
module sli_top_sva #(
  parameter int unsigned NPORT     = 3,
  parameter int unsigned NDI       = 8,
  parameter int unsigned LONG_CYC  = 20,
  parameter int unsigned SHORT_CYC = 6
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic [7:0]       s_axi_awaddr,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic [NPORT-1:0] port_rx_active,
  input wire logic [NPORT-1:0] led_rx,
  input wire logic [NDI-1:0]   din_point,
  input wire logic [NDI-1:0]   led_din,
  input wire logic             led_status
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  wa_r;
  logic [7:0]  ra_r;
  int unsigned on_r;
  int unsigned quiet_r;
  logic        cut_r;

  // Expected response for a word address
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a[1:0] == 2'h0 && a <= sli_pkg::OFS_LEDS) ?
      sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
  endfunction : resp_of

  // ======
  // Helper state: a write may cut a flash short, so mark it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_r    <= 0;
      cut_r   <= 1'h1;
      quiet_r <= 0;
    end else begin
      on_r <= led_status ? on_r + 1 : 0;
      if (s_axi_awvalid && s_axi_awready) begin
        cut_r   <= 1'h1;
        quiet_r <= 0;
      end else begin
        if (quiet_r < 8) quiet_r <= quiet_r + 1;
        // A flash that rises within a few cycles of a write may be cut
        if (led_status && on_r == 0) cut_r <= (quiet_r < 4);
      end
    end
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end

  // ======
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence

  a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_b_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == resp_of(wa_r))
    else $error("write response code wrong");
  a_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp == resp_of(ra_r)
    && (s_axi_rresp == sli_pkg::RESP_OKAY || s_axi_rdata == 32'h0))
    else $error("read response wrong");
  a_rx_cause: assert property ((led_rx & ~$past(port_rx_active)) == '0)
    else $error("receive LED lit without activity");
  a_din_cause: assert property ((led_din & ~$past(din_point)) == '0)
    else $error("input LED lit with input off");
  a_flash_len: assert property ($fell(led_status) && !cut_r |->
    on_r == LONG_CYC || on_r == SHORT_CYC)
    else $error("flash length wrong");
endmodule : sli_top_sva

bind sli_top sli_top_sva #(.NPORT(NPORT), .NDI(NDI), .LONG_CYC(LONG_CYC),
  .SHORT_CYC(SHORT_CYC)) sli_top_sva_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .port_rx_active, .led_rx,
  .din_point, .led_din, .led_status);

// [verif/sli_top_tb.sv]
// Purpose: Self-checking bench for the indicator controller.
// Assumes: Shortened flash timing; default port and point counts.
// Notes:   Expected patterns come from the bench model, never the design.
module sli_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP = 40, LONG = 20, SHORT = 6, SPACE = 10, BLIP = 3;
  logic aclk = 0, aresetn = 0, io_module_fault = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, led_status, led_power, led_run, led_force;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, din_point = 0;
  logic [7:0] ai_range_err = 0, led_din, led_dout, led_ai;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] port_rx_active = 0, port_tx_active = 0, port_cts = 0;
  logic [2:0] port_dcd = 0, cnt_present = 0, cnt_level = 0, cnt_pulse = 0;
  logic [2:0] led_rx, led_tx, led_cts, led_dcd, led_cnt;
  logic seg_done, seg_lit;
  int seg_len, num_errors = 0, checks_done = 0, cyc = 0;

  sli_top #(.GAP_CYC(GAP), .LONG_CYC(LONG), .SHORT_CYC(SHORT),
    .SPACE_CYC(SPACE), .BLIP_CYC(BLIP)) sli_top_i (.*);
  sli_panel sli_panel_i (.*);

  // ======
  // Clock and a watchdog against a hung handshake
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    rsp  = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // Model of the flash pattern after a write; first dark stretch dropped
  task automatic show(input logic [7:0] wa, input logic [7:0] wc,
                      input logic [7:0] ec);
    int e[$];
    int q[$];
    int m;
    int g;
    wr(wa, {24'h0, wc});
    m = 0;
    for (int i = 0; i < 8; i++) if (ec[i]) m = i;
    for (int i = 0; i <= m; i++) begin
      e.push_back(ec[i] ? LONG : SHORT);
      e.push_back(i == m ? -GAP : -SPACE);
    end
    while (q.size() < 2 * e.size() + 1) begin
      @(posedge aclk);
      if (seg_done === 1'h1) q.push_back(seg_lit ? seg_len : -seg_len);
    end
    void'(q.pop_front());
    foreach (q[i]) begin
      g = (q[i] == -GAP - 1) ? -GAP : q[i];
      chk(g, e[i % e.size()]);
    end
  endtask : show

  task automatic results();
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // ======
  // Main sequence
  initial begin
    logic [31:0] ctl, st, dv, ai, rn;
    logic [2:0] ce;
    int n;
    void'($urandom(75337));
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(sli_pkg::OFS_CTRL);
    chk(rdat, sli_pkg::CTRL_RST);
    rd(sli_pkg::OFS_CODE);
    chk(rdat, 32'h0);
    wr(8'h40, 32'h1);
    chk(rsp, sli_pkg::RESP_SLVERR);
    rd(8'h42);
    chk(rsp, sli_pkg::RESP_SLVERR);
    chk(rdat, 32'h0);
    wr(sli_pkg::OFS_LEDS, 32'hff);
    chk(rsp, sli_pkg::RESP_OKAY);
    // Codes, each after the first started by a stop in mid-pattern
    rn = 32'h9605_0201;
    for (int k = 0; k < 4; k++) begin
      ai = {24'h0, rn[8*k +: 8]};
      wr(sli_pkg::OFS_CODE, 32'h0);
      repeat (2) @(posedge aclk);
      chk(led_status, 1'h0);
      show(sli_pkg::OFS_CODE, ai[7:0], ai[7:0]);
    end
    wr(sli_pkg::OFS_CODE, 32'h0);
    // Module fault shows as code one once the mask is lifted
    wr(sli_pkg::OFS_CTRL, 32'h3);
    io_module_fault <= 1'h1;
    show(sli_pkg::OFS_CTRL, 8'h01, 8'h01);
    wr(sli_pkg::OFS_CTRL, 32'h3);
    repeat (100) @(posedge aclk);
    n = 0;
    repeat (100) @(posedge aclk) n += led_status;
    chk(n, 0);
    io_module_fault <= 1'h0;
    // Reduced power: one brief blink per period
    wr(sli_pkg::OFS_STATE, 32'h4);
    n = 0;
    repeat (2 * GAP) @(posedge aclk) n += led_power;
    chk(n >= BLIP && n <= 3 * BLIP, 1'h1);
    // Random state, points and enable against the level model
    for (int r = 0; r < 24; r++) begin
      ctl = ($urandom & 32'hc) | (r % 4 != 3);
      st = ($urandom & 32'h3) | (($urandom & 32'h1) << 3);
      dv = $urandom & 32'hff;
      ai = $urandom & 32'hff;
      wr(sli_pkg::OFS_CTRL, ctl);
      wr(sli_pkg::OFS_STATE, st);
      wr(sli_pkg::OFS_DOUT, dv);
      wr(sli_pkg::OFS_AICFG, ai);
      rd(sli_pkg::OFS_STATE);
      chk(rdat, st);
      rn = $urandom;
      {port_rx_active, port_tx_active, port_cts, port_dcd} <= rn[11:0];
      {cnt_present, cnt_level, cnt_pulse} <= rn[20:12];
      {din_point, ai_range_err} <= 16'($urandom);
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 3; i++) begin
        ce[i] = ((i == 0 || ctl[i+1]) ? cnt_present[i] & ~cnt_level[i]
          : cnt_pulse[i]) & ctl[0];
      end
      chk(led_cnt, ce);
      chk(led_run, st[0] & ctl[0]);
      chk(led_force, st[1] & ctl[0]);
      chk(led_power, ~st[3] & ctl[0]);
      chk({led_rx, led_tx}, {port_rx_active, port_tx_active} & {6{ctl[0]}});
      chk({led_cts, led_dcd}, {port_cts, port_dcd} & {6{ctl[0]}});
      chk({led_din, led_dout}, {din_point, dv[7:0]} & {16{ctl[0]}});
      chk(led_ai & ~ai_range_err, ai[7:0] & ~ai_range_err & {8{ctl[0]}});
      chk(led_status, 1'h0);
    end
    results();
  end
endmodule : sli_top_tb
